// *** design/ldim_defines.svh ***
// Bit positions, register offsets, reset values and timing counts for the mode-set block.
`ifndef LDIM_DEFINES_SVH
`define LDIM_DEFINES_SVH

// Address pins seen by the block and the captured mode-field positions.
`define LDIM_ADDR_W        19
`define LDIM_CAPTURE_MSB   17
`define LDIM_CFG_MSB       2
`define LDIM_BL_LSB        3
`define LDIM_BL_MSB        4
`define LDIM_MUX_BIT       5
`define LDIM_DLL_BIT       7
`define LDIM_IMP_BIT       8
`define LDIM_ODT_BIT       9
`define LDIM_AY_CFG_LO     3
`define LDIM_AY_CFG_HI     4
`define LDIM_AY_DLL_BIT    9
`define LDIM_CFG_RESET     3'h0
`define LDIM_BL_RESET      2'h0

// Register byte offsets on the AXI4-Lite port.
`define LDIM_AXI_AW        12
`define LDIM_OFF_MODE      12'h000
`define LDIM_OFF_STATUS    12'h004
`define LDIM_OFF_LAT       12'h008
`define LDIM_OFF_CTRL      12'h00C
`define LDIM_RESP_OKAY     2'h0
`define LDIM_RESP_SLVERR   2'h2

// Status bit positions.
`define LDIM_ST_DONE       0
`define LDIM_ST_MUX        1
`define LDIM_ST_LOCK       2
`define LDIM_ST_RSVD       3
`define LDIM_ST_EARLY      4
`define LDIM_ST_SEQ        5

// Timing: stable-clock wait in microseconds, clock rate in MHz, and derived cycle counts.
`define LDIM_STABLE_TIME_US 200
`define LDIM_CLK_MHZ        250
`define LDIM_STABLE_CYC     (`LDIM_STABLE_TIME_US * `LDIM_CLK_MHZ)
`define LDIM_DLL_LOCK_CYC   11'h400
`define LDIM_INIT_NOPS      11'h400
`define LDIM_MIN_LOADS      2'h3
`define LDIM_BANKS          8

`endif

// *** design/ldim_pkg.sv ***
// Types shared by the mode-set block: bus commands and init tracking states.
package ldim_pkg;

    // Command decoded from the control pins on a rising clock edge.
    typedef enum logic [1:0] {
        LDIM_CMD_NOP,
        LDIM_CMD_MODE_LOAD,
        LDIM_CMD_BANK_REFRESH,
        LDIM_CMD_OTHER
    } ldim_cmd_t;

    // Progress of the power-up sequence as seen by the memory.
    typedef enum logic [1:0] {
        LDIM_ST_POWERUP,
        LDIM_ST_LOADS,
        LDIM_ST_FILL,
        LDIM_ST_READY
    } ldim_state_t;

endpackage : ldim_pkg

// *** design/ldim_lat_decode.sv ***
// Latency and row-cycle decoder for the configuration field.
module ldim_lat_decode (
    // Configuration code and address mode.
    input  wire logic [2:0] cfg_code,
    input  wire logic       mux_mode,
    // Decoded cycle counts.
    output logic      [3:0] row_cycle_time,
    output logic      [3:0] read_latency_cycles,
    output logic      [3:0] write_latency_cycles,
    output logic            reserved
);
    logic [3:0] base_lat;

    // Table lookup; reserved codes fall back to the default timing.
    always_comb begin
        reserved = 1'b0;
        base_lat = 4'h4;
        row_cycle_time = 4'h4;
        case (cfg_code)
            3'h2: begin
                row_cycle_time = 4'h6;
                base_lat       = 4'h6;
            end
            3'h3: begin
                row_cycle_time = 4'h8;
                base_lat       = 4'h8;
            end
            3'h4: begin
                row_cycle_time = 4'h3;
                base_lat       = 4'h3;
            end
            3'h5: begin
                row_cycle_time = 4'h5;
                base_lat       = 4'h5;
            end
            3'h6, 3'h7: begin
                reserved = 1'b1;
            end
            default: begin
                row_cycle_time = 4'h4;
                base_lat       = 4'h4;
            end
        endcase
        read_latency_cycles  = base_lat + {3'h0, mux_mode};
        write_latency_cycles = read_latency_cycles + 4'h1;
    end

endmodule : ldim_lat_decode

// *** design/ldim_mode_set.sv ***
// Power-up tracking and mode-register capture for the eight-bank memory, with AXI4-Lite access.
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`include "ldim_defines.svh"

module ldim_mode_set #(
    parameter int STABLE_CYC = `LDIM_STABLE_CYC
) (
    // Clock and reset.
    input  wire logic                        sys_clk,
    input  wire logic                        reset,
    // Command, bank and address pins, sampled on the command clock.
    input  wire ldim_pkg::ldim_cmd_t         dram_cmd,
    input  wire logic [2:0]                  bank_select_bits,
    input  wire logic [`LDIM_ADDR_W-1:0]     dram_addr,
    // AXI4-Lite register port.
    input  wire logic [`LDIM_AXI_AW-1:0]     s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [`LDIM_AXI_AW-1:0]     s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // Operating configuration handed to the core.
    output logic [3:0]                       row_cycle_time,
    output logic [3:0]                       read_latency_cycles,
    output logic [3:0]                       write_latency_cycles,
    output logic [1:0]                       burst_count_setting,
    output logic                             mux_mode,
    output logic                             dll_enable,
    output logic                             dll_locked,
    output logic                             impedance_match_en,
    output logic                             on_die_termination,
    output logic                             init_done
);
    import ldim_pkg::*;

    // Mode and tracking state.
    ldim_state_t state_q, state_d;
    logic [2:0]  cfg_q, cfg_d;
    logic [1:0]  bl_q, bl_d;
    logic        mux_q, mux_d, dll_q, dll_d, imp_q, imp_d, odt_q, odt_d;
    logic        ph2_q, ph2_d;
    logic [9:0]  ax_q, ax_d;
    logic [1:0]  loads_q, loads_d;
    logic [7:0]  ref_q, ref_d;
    logic [10:0] nops_q, nops_d, lock_q, lock_d;
    logic [31:0] stable_q, stable_d;
    logic        rsvd_q, rsvd_d, early_q, early_d, seq_q, seq_d;
    logic [3:0]  trc_q, trl_q, twl_q;
    logic        done_q, lockd_q;
    // Candidate capture for the decoder.
    logic [2:0]  new_cfg;
    logic        new_mux, apply;
    logic [3:0]  dec_trc, dec_trl, dec_twl;
    logic        dec_rsvd;
    // Register bus state.
    logic        awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
    logic        awf_q, awf_d, wf_q, wf_d;
    logic [`LDIM_AXI_AW-1:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;
    logic        do_wr, restart, clr_rsvd, clr_early, clr_seq;

    ldim_lat_decode u_dec (
        .cfg_code             (new_cfg),
        .mux_mode             (new_mux),
        .row_cycle_time       (dec_trc),
        .read_latency_cycles  (dec_trl),
        .write_latency_cycles (dec_twl),
        .reserved             (dec_rsvd)
    );

    // Decides which address bits form the new mode and whether a load lands this cycle.
    always_comb begin
        apply   = 1'b0;
        new_cfg = cfg_q;
        new_mux = mux_q;
        if (ph2_q) begin
            apply   = 1'b1;
            new_mux = 1'b1;
            new_cfg = {dram_addr[`LDIM_AY_CFG_HI], dram_addr[`LDIM_AY_CFG_LO], ax_q[0]};
        end else if (dram_cmd == LDIM_CMD_MODE_LOAD && !mux_q) begin
            apply   = 1'b1;
            new_mux = dram_addr[`LDIM_MUX_BIT];
            new_cfg = dram_addr[`LDIM_CFG_MSB:0];
        end
    end

    // Next-state logic for mode capture, init tracking and the loop lock timer.
    always_comb begin
        state_d  = state_q;
        cfg_d    = cfg_q;
        bl_d     = bl_q;
        mux_d    = mux_q;
        dll_d    = dll_q;
        imp_d    = imp_q;
        odt_d    = odt_q;
        ph2_d    = 1'b0;
        ax_d     = ax_q;
        loads_d  = loads_q;
        ref_d    = ref_q;
        nops_d   = nops_q;
        lock_d   = lock_q;
        stable_d = (stable_q < STABLE_CYC) ? stable_q + 32'h1 : stable_q;
        rsvd_d   = rsvd_q & ~clr_rsvd;
        early_d  = early_q & ~clr_early;
        seq_d    = seq_q & ~clr_seq;
        // First phase of a multiplexed load is kept only when bit 5 is high.
        if (dram_cmd == LDIM_CMD_MODE_LOAD && mux_q && !ph2_q
            && dram_addr[`LDIM_MUX_BIT]) begin
            ph2_d = 1'b1;
            ax_d  = dram_addr[9:0];
        end
        if (apply) begin
            if (dec_rsvd) begin
                rsvd_d = 1'b1;
            end else begin
                cfg_d = new_cfg;
            end
            mux_d = new_mux;
            if (ph2_q) begin
                bl_d  = ax_q[`LDIM_BL_MSB:`LDIM_BL_LSB];
                dll_d = dram_addr[`LDIM_AY_DLL_BIT];
                imp_d = ax_q[`LDIM_IMP_BIT];
                odt_d = ax_q[`LDIM_ODT_BIT];
            end else begin
                bl_d  = dram_addr[`LDIM_BL_MSB:`LDIM_BL_LSB];
                dll_d = dram_addr[`LDIM_DLL_BIT];
                imp_d = dram_addr[`LDIM_IMP_BIT];
                odt_d = dram_addr[`LDIM_ODT_BIT];
            end
        end
        // Loop lock time restarts on every applied load; a low enable keeps the loop off.
        if (apply || !dll_q) begin
            lock_d = 11'h0;
        end else if (lock_q != `LDIM_DLL_LOCK_CYC) begin
            lock_d = lock_q + 11'h1;
        end
        if (dram_cmd == LDIM_CMD_MODE_LOAD && stable_q < STABLE_CYC) begin
            early_d = 1'b1;
        end
        // Power-up sequence tracking.
        case (state_q)
            LDIM_ST_POWERUP: begin
                if (dram_cmd == LDIM_CMD_MODE_LOAD) begin
                    state_d = LDIM_ST_LOADS;
                    loads_d = 2'h1;
                end
            end
            LDIM_ST_LOADS: begin
                if (dram_cmd == LDIM_CMD_MODE_LOAD) begin
                    loads_d = (loads_q == `LDIM_MIN_LOADS) ? loads_q : loads_q + 2'h1;
                end else if (loads_q == `LDIM_MIN_LOADS) begin
                    state_d = LDIM_ST_FILL;
                    ref_d   = 8'h0;
                    nops_d  = 11'h0;
                end else begin
                    state_d = LDIM_ST_POWERUP;
                    seq_d   = 1'b1;
                end
            end
            LDIM_ST_FILL: begin
                if (dram_cmd == LDIM_CMD_NOP && nops_q != `LDIM_INIT_NOPS) begin
                    nops_d = nops_q + 11'h1;
                end else if (dram_cmd == LDIM_CMD_BANK_REFRESH) begin
                    ref_d = ref_q | (8'h1 << bank_select_bits);
                end
                if (&ref_d && nops_d == `LDIM_INIT_NOPS) begin
                    state_d = LDIM_ST_READY;
                end
            end
            default: begin
                state_d = LDIM_ST_READY;
            end
        endcase
        if (restart) begin
            state_d = LDIM_ST_POWERUP;
        end
    end

    // Registers for mode, tracking and the decoded timing outputs.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q  <= LDIM_ST_POWERUP;
            cfg_q    <= `LDIM_CFG_RESET;
            bl_q     <= `LDIM_BL_RESET;
            {mux_q, dll_q, imp_q, odt_q, ph2_q} <= 5'h00;
            ax_q     <= 10'h000;
            loads_q  <= 2'h0;
            ref_q    <= 8'h00;
            nops_q   <= 11'h000;
            lock_q   <= 11'h000;
            stable_q <= 32'h0000_0000;
            {rsvd_q, early_q, seq_q} <= 3'h0;
            trc_q    <= 4'h4;
            trl_q    <= 4'h4;
            twl_q    <= 4'h5;
            done_q   <= 1'b0;
            lockd_q  <= 1'b0;
        end else begin
            state_q  <= state_d;
            cfg_q    <= cfg_d;
            bl_q     <= bl_d;
            {mux_q, dll_q, imp_q, odt_q, ph2_q} <= {mux_d, dll_d, imp_d, odt_d, ph2_d};
            ax_q     <= ax_d;
            loads_q  <= loads_d;
            ref_q    <= ref_d;
            nops_q   <= nops_d;
            lock_q   <= lock_d;
            stable_q <= stable_d;
            {rsvd_q, early_q, seq_q} <= {rsvd_d, early_d, seq_d};
            if (apply && !dec_rsvd) begin
                trc_q <= dec_trc;
                trl_q <= dec_trl;
                twl_q <= dec_twl;
            end
            done_q   <= (state_d == LDIM_ST_READY);
            lockd_q  <= dll_d && (lock_d == `LDIM_DLL_LOCK_CYC);
        end
    end

    // Write decode: each strobe comes from a completed write to its register.
    assign do_wr     = awf_q && wf_q && !bv_q;
    assign restart   = do_wr && awa_q == `LDIM_OFF_CTRL && wd_q[0];
    assign clr_rsvd  = do_wr && awa_q == `LDIM_OFF_STATUS && wd_q[`LDIM_ST_RSVD];
    assign clr_early = do_wr && awa_q == `LDIM_OFF_STATUS && wd_q[`LDIM_ST_EARLY];
    assign clr_seq   = do_wr && awa_q == `LDIM_OFF_STATUS && wd_q[`LDIM_ST_SEQ];

    // AXI4-Lite slave: address and data taken in either order, one response per write.
    always_comb begin
        awf_d = awf_q | (s_axi_awvalid & awr_q);
        wf_d  = wf_q | (s_axi_wvalid & wr_q);
        awa_d = (s_axi_awvalid & awr_q) ? s_axi_awaddr : awa_q;
        wd_d  = (s_axi_wvalid & wr_q) ? (s_axi_wdata & {{8{s_axi_wstrb[3]}},
                {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}}) : wd_q;
        bv_d  = bv_q & ~s_axi_bready;
        br_d  = br_q;
        if (do_wr) begin
            awf_d = 1'b0;
            wf_d  = 1'b0;
            bv_d  = 1'b1;
            if (awa_q == `LDIM_OFF_MODE || awa_q == `LDIM_OFF_STATUS
                || awa_q == `LDIM_OFF_LAT || awa_q == `LDIM_OFF_CTRL) begin
                br_d = `LDIM_RESP_OKAY;
            end else begin
                br_d = `LDIM_RESP_SLVERR;
            end
        end
        awr_d = ~awf_d;
        wr_d  = ~wf_d;
        rv_d  = rv_q & ~s_axi_rready;
        rd_d  = rd_q;
        rr_d  = rr_q;
        if (s_axi_arvalid && arr_q) begin
            rv_d = 1'b1;
            rr_d = `LDIM_RESP_OKAY;
            if (s_axi_araddr == `LDIM_OFF_MODE) begin
                rd_d = {22'h0, odt_q, imp_q, dll_q, 1'b0, mux_q, bl_q, cfg_q};
            end else if (s_axi_araddr == `LDIM_OFF_STATUS) begin
                rd_d = {5'h0, nops_q, ref_q, 2'h0, seq_q, early_q, rsvd_q,
                        lockd_q, mux_q, done_q};
            end else if (s_axi_araddr == `LDIM_OFF_LAT) begin
                rd_d = {12'h0, twl_q, 4'h0, trl_q, 4'h0, trc_q};
            end else if (s_axi_araddr == `LDIM_OFF_CTRL) begin
                rd_d = 32'h0000_0000;
            end else begin
                rd_d = 32'h0000_0000;
                rr_d = `LDIM_RESP_SLVERR;
            end
        end
        arr_d = ~rv_d;
    end

    // Register bus flip-flops.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            {awf_q, wf_q, bv_q, rv_q} <= 4'h0;
            {awr_q, wr_q, arr_q}      <= 3'h7;
            awa_q <= 12'h000;
            wd_q  <= 32'h0000_0000;
            rd_q  <= 32'h0000_0000;
            br_q  <= 2'h0;
            rr_q  <= 2'h0;
        end else begin
            {awf_q, wf_q, bv_q, rv_q} <= {awf_d, wf_d, bv_d, rv_d};
            {awr_q, wr_q, arr_q}      <= {awr_d, wr_d, arr_d};
            awa_q <= awa_d;
            wd_q  <= wd_d;
            rd_q  <= rd_d;
            br_q  <= br_d;
            rr_q  <= rr_d;
        end
    end

    // Outputs straight from flip-flops.
    assign s_axi_awready        = awr_q;
    assign s_axi_wready         = wr_q;
    assign s_axi_bvalid         = bv_q;
    assign s_axi_bresp          = br_q;
    assign s_axi_arready        = arr_q;
    assign s_axi_rvalid         = rv_q;
    assign s_axi_rdata          = rd_q;
    assign s_axi_rresp          = rr_q;
    assign row_cycle_time       = trc_q;
    assign read_latency_cycles  = trl_q;
    assign write_latency_cycles = twl_q;
    assign burst_count_setting  = bl_q;
    assign mux_mode             = mux_q;
    assign dll_enable           = dll_q;
    assign dll_locked           = lockd_q;
    assign impedance_match_en   = imp_q;
    assign on_die_termination   = odt_q;
    assign init_done            = done_q;

endmodule : ldim_mode_set

// *** tb/ldim_mode_set_props.sv ***
// Checker for the mode-set block's configuration outputs.
`include "ldim_defines.svh"
module ldim_mode_set_props (
    // Clock, reset and command pins.
    input wire logic                    sys_clk,
    input wire logic                    reset,
    input wire ldim_pkg::ldim_cmd_t     dram_cmd,
    input wire logic [`LDIM_ADDR_W-1:0] dram_addr,
    // Configuration outputs.
    input wire logic [3:0]              row_cycle_time,
    input wire logic [3:0]              read_latency_cycles,
    input wire logic [3:0]              write_latency_cycles,
    input wire logic [1:0]              burst_count_setting,
    input wire logic                    mux_mode,
    input wire logic                    dll_enable,
    input wire logic                    dll_locked,
    input wire logic                    impedance_match_en,
    input wire logic                    on_die_termination
);
    timeunit 1ns;
    timeprecision 1ps;
    import ldim_pkg::*;
    localparam logic [3:0] ROW_CYCLE_TIME [8] = '{4'h4, 4'h4, 4'h6, 4'h8, 4'h3, 4'h5, 4'h0, 4'h0};
    logic        ld;
    logic [10:0] since_q;
    logic [10:0] since_d;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Cycles since the last load, saturating.
    assign ld = (dram_cmd == LDIM_CMD_MODE_LOAD);
    always_comb begin
        since_d = ld ? 11'h000 : since_q + {10'h000, ~&since_q};
    end
    always_ff @(posedge sys_clk) begin
        since_q <= reset ? 11'h000 : since_d;
    end
    // Latency relations and decode after each load.
    a_wl_plus_one: assert property (write_latency_cycles == read_latency_cycles + 4'h1)
        else $error("write latency not read plus one");
    a_mux_offset: assert property ($stable(mux_mode) |->
        read_latency_cycles == row_cycle_time + {3'h0, mux_mode})
        else $error("read latency mode offset wrong");
    a_nonmux_decode: assert property (
        ld && !mux_mode && !dram_addr[5] && dram_addr[2:0] < 3'h6 |=>
        row_cycle_time == ROW_CYCLE_TIME[$past(dram_addr[2:0])] &&
        read_latency_cycles == ROW_CYCLE_TIME[$past(dram_addr[2:0])])
        else $error("one-edge decode wrong");
    a_mux_decode: assert property (
        ld && mux_mode && dram_addr[5] ##1 {dram_addr[4:3], $past(dram_addr[0])} < 3'h6 |=>
        row_cycle_time == ROW_CYCLE_TIME[{$past(dram_addr[4:3]), $past(dram_addr[0], 2)}])
        else $error("two-edge decode wrong");
    a_fields_capture: assert property (
        ld && !mux_mode && !dram_addr[5] |=> dll_enable == $past(dram_addr[7]) &&
        impedance_match_en == $past(dram_addr[8]) && on_die_termination == $past(dram_addr[9])
        && burst_count_setting == $past(dram_addr[4:3]))
        else $error("feature fields not captured");
    a_mux_select: assert property (ld && dram_addr[5] && !mux_mode |=> mux_mode)
        else $error("bit five did not select mux mode");
    a_mux_sticky: assert property (mux_mode |=> mux_mode)
        else $error("mux mode left");
    a_lock_count: assert property ($rose(dll_locked) |-> dll_enable && since_q >= 11'h3F8)
        else $error("loop lock came too early");
endmodule : ldim_mode_set_props

bind ldim_mode_set ldim_mode_set_props u_props (.sys_clk, .reset, .dram_cmd, .dram_addr,
    .row_cycle_time, .read_latency_cycles, .write_latency_cycles, .burst_count_setting,
    .mux_mode, .dll_enable, .dll_locked, .impedance_match_en, .on_die_termination);

// *** tb/ldim_ctrl_model.sv ***
// Memory controller model driving the command pins.
`include "ldim_defines.svh"
module ldim_ctrl_model #(
    parameter int STABLE = 20,
    parameter int SETTLE = 8
) (
    // Command clock.
    input  wire logic                   sys_clk,
    // Pins toward the memory.
    output ldim_pkg::ldim_cmd_t         dram_cmd,
    output logic [2:0]                  bank_select_bits,
    output logic [`LDIM_ADDR_W-1:0]     dram_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    import ldim_pkg::*;
    // Pins start idle.
    initial begin
        dram_cmd = LDIM_CMD_NOP;
        bank_select_bits = 3'h0;
        dram_addr = '0;
    end
    // One command per rising edge, changed just after the edge.
    task automatic issue(input ldim_cmd_t c, input logic [2:0] b, input logic [18:0] a);
        @(posedge sys_clk);
        dram_cmd <= c;
        bank_select_bits <= b;
        dram_addr <= a;
    endtask : issue
    // Idle cycles with toggling address lines.
    task automatic nop(input int n);
        repeat (n) issue(LDIM_CMD_NOP, ~bank_select_bits, ~dram_addr);
    endtask : nop
    // Single-edge load, then the settle time.
    task automatic load(input logic [18:0] a);
        issue(LDIM_CMD_MODE_LOAD, 3'h0, a);
        nop(SETTLE);
    endtask : load
    // Two-edge load: phases on two consecutive edges.
    task automatic mload(input logic [18:0] ax, input logic [18:0] ay);
        issue(LDIM_CMD_MODE_LOAD, 3'($urandom), ax);
        issue(LDIM_CMD_NOP, 3'h0, ay);
        nop(SETTLE);
    endtask : mload
    // Power-up: stable wait, three loads, refreshes among fill cycles.
    task automatic init(input logic [18:0] a);
        logic [2:0] r;
        r = 3'($urandom);
        nop(STABLE + 2);
        issue(LDIM_CMD_MODE_LOAD, 3'h0, '0);
        issue(LDIM_CMD_MODE_LOAD, 3'h0, '0);
        issue(LDIM_CMD_MODE_LOAD, 3'h0, a);
        nop(SETTLE);
        for (int i = 0; i < 8; i++) begin
            issue(LDIM_CMD_BANK_REFRESH, 3'(i) ^ r, '0);
            nop(128);
        end
    endtask : init
endmodule : ldim_ctrl_model

// *** tb/test_lowlatency_dram_init_mode_set.sv ***
// Self-checking bench for the mode-set block.
`include "ldim_defines.svh"
module test_lowlatency_dram_init_mode_set;
    timeunit 1ns;
    timeprecision 1ps;
    import ldim_pkg::*;
    localparam int         STABLE = 20;
    localparam logic [3:0] ROW_CYCLE_TIME [8] = '{4'h4, 4'h4, 4'h6, 4'h8, 4'h3, 4'h5, 4'h0, 4'h0};
    logic        sys_clk, reset, init_done, mux_mode, dll_enable, dll_locked;
    logic        impedance_match_en, on_die_termination, s_axi_awvalid, s_axi_awready;
    logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, burst_count_setting, rs;
    logic [2:0]  bank_select_bits, last;
    logic [3:0]  s_axi_wstrb, row_cycle_time, read_latency_cycles, write_latency_cycles;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [18:0] dram_addr, a;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    ldim_cmd_t   dram_cmd;
    int          errors = 0, n_compared = 0, cyc = 0;
    ldim_ctrl_model #(.STABLE(STABLE), .SETTLE(8)) ctl (.sys_clk, .dram_cmd, .bank_select_bits,
        .dram_addr);
    ldim_mode_set #(.STABLE_CYC(STABLE)) uut (.sys_clk, .reset, .dram_cmd, .bank_select_bits,
        .dram_addr, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .row_cycle_time, .read_latency_cycles,
        .write_latency_cycles, .burst_count_setting, .mux_mode, .dll_enable, .dll_locked,
        .impedance_match_en, .on_die_termination, .init_done);
    // Clock and a cycle ceiling against hangs.
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors = errors + 1;
            end_sim();
        end
    end
    // Counted comparison.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk
    // Bus write: address and data together.
    task automatic axi_wr(input logic [11:0] ad, input logic [31:0] wd);
        @(posedge sys_clk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    // Bus read: data taken at the rvalid edge.
    task automatic axi_rd(input logic [11:0] ad);
        @(posedge sys_clk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    // Latency outputs against the table.
    task automatic chk_lat(input logic [2:0] c, input logic [3:0] m);
        chk(row_cycle_time, ROW_CYCLE_TIME[c]);
        chk(read_latency_cycles, ROW_CYCLE_TIME[c] + m);
        chk(write_latency_cycles, ROW_CYCLE_TIME[c] + m + 4'h1);
    endtask : chk_lat
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    // Main sequence.
    initial begin
        reset = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr} = 24'h00_0000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        d = $urandom(32'h0000_02c5);
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        // Two loads too early and too few are flagged, then cleared.
        ctl.issue(LDIM_CMD_MODE_LOAD, 3'h0, '0);
        ctl.issue(LDIM_CMD_MODE_LOAD, 3'h0, '0);
        ctl.nop(4);
        axi_rd(`LDIM_OFF_STATUS);
        chk(d[5:4], 2'h3);
        axi_wr(`LDIM_OFF_STATUS, 32'h0000_0030);
        axi_rd(`LDIM_OFF_STATUS);
        chk(d[5:4], 2'h0);
        chk(init_done, 1'b0);
        // Full power-up with a random valid configuration.
        last = 3'($urandom_range(5));
        a = {9'h000, 3'($urandom), 2'h0, (last inside {3'h0, 3'h1, 3'h4}) ? 2'h0 : 2'($urandom), last};
        ctl.init(a);
        chk(init_done, 1'b1);
        chk_lat(last, 4'h0);
        axi_rd(`LDIM_OFF_MODE);
        chk(d, a[9:0]);
        axi_rd(`LDIM_OFF_LAT);
        chk(d, {12'h000, ROW_CYCLE_TIME[last] + 4'h1, 4'h0, ROW_CYCLE_TIME[last], 4'h0, ROW_CYCLE_TIME[last]});
        // Every code; reserved ones keep the old setting.
        for (int c = 0; c < 8; c++) begin
            ctl.load(19'(c));
            if (c < 6) last = 3'(c);
            chk_lat(last, 4'h0);
        end
        axi_rd(`LDIM_OFF_STATUS);
        chk(d[3], 1'b1);
        // Loop enable and lock after its count.
        ctl.load(19'h0_0082);
        repeat (1000) @(posedge sys_clk);
        chk(dll_locked, 1'b0);
        for (int i = 0; i < 100 && dll_locked !== 1'b1; i++) @(posedge sys_clk);
        chk({dll_locked, dll_enable}, 2'h3);
        // Mux mode and two-edge loads of each valid code.
        ctl.load(19'h0_0020);
        chk(mux_mode, 1'b1);
        for (int c = 0; c < 6; c++) begin
            ctl.mload(19'h0_0020 | 19'(c[0]), (19'($urandom) & 19'h0_00C6) | 19'({c[2:1], 3'h0}));
            chk_lat(3'(c), 4'h1);
        end
        // Unmapped place, then restart of init tracking.
        axi_rd(12'h010);
        chk({rs, d[29:0]}, 32'h8000_0000);
        axi_wr(12'h010, $urandom);
        chk(rs, `LDIM_RESP_SLVERR);
        axi_wr(`LDIM_OFF_CTRL, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        chk({rs, init_done}, {`LDIM_RESP_OKAY, 1'b0});
        end_sim();
    end
endmodule : test_lowlatency_dram_init_mode_set
